// *** bench/offline_pwm_converter_control_tb_top.sv ***
// Self-checking bench for the converter control top
`timescale 1ns/1ns
`default_nettype none
module offline_pwm_converter_control_tb_top;
   import opc_pkg::*;
   localparam longint RS_CYC = 500;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   opc_sense_t sns = '0;
   opc_sense_t sense_w;
   logic [7:0] lim_set = 8'h00;
   logic [1:0] load = 2'h0;
   logic pwm_m;
   logic lim_m;
   opc_drive_t drv;
   logic burst;
   logic ovl;
   int errors = 0;
   int check_count = 0;
   int cyc = 0;
   int n;
   int m;
   always #5 clk_in = ~clk_in;
   // Comparator flags come from the far-side model
   always_comb begin
      sense_w = sns;
      sense_w.pwm_trip = pwm_m;
      sense_w.limit_trip = lim_m;
   end
   opc_control #(.HIGH_FREQ(1'b1), .SOFT_START_CYC_P(2000),
      .RESTART_CYC_P(RS_CYC), .SWEEP_CYC_P(20000), .OVERLOAD_SW_P(4)) dut_u (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .sense_in(sense_w),
      .limit_set_code_in(lim_set),
      .drive_out(drv),
      .burst_out(burst),
      .overload_out(ovl)
   );
   opc_sense_model model_u (
      .clk_in(clk_in),
      .gate_in(drv.gate),
      .load_in(load),
      .pwm_trip_out(pwm_m),
      .limit_trip_out(lim_m)
   );
   task automatic wrap_up();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Hang guard sized well above the planned sequence
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 60000) begin
         errors++;
         wrap_up();
      end
   end
   task automatic chk(input string what, input logic [7:0] exp,
      input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic flag(input int sel);
      case (sel)
         0: return drv.gate;
         1: return burst;
         2: return ovl;
         default: return drv.charger_en;
      endcase
   endfunction
   // Bounded wait at falling edges, then judge the flag
   task automatic wait_for(input string what, input int sel, input logic val,
      input int limit_set_pin, output int cnt);
      cnt = 0;
      while (cnt < limit_set_pin && flag(sel) !== val) begin
         @(negedge clk_in);
         cnt++;
      end
      chk(what, {7'h00, val}, {7'h00, flag(sel)});
   endtask
   task automatic t_startup();
      chk("reset gate", 8'h00, {7'h00, drv.gate});
      chk("reset limit", LIM_SS_START, drv.limit_code);
      rst_n_in = 1'b1;
      sns.drain_start = 1'b1;
      wait_for("charger on", 3, 1'b1, 20, n);
      chk("gate charge", 8'h00, {7'h00, drv.gate});
      sns.above_turn_off = 1'b1;
      sns.above_charger_on = 1'b1;
      sns.above_turn_on = 1'b1;
      wait_for("charger off", 3, 1'b0, 20, n);
      wait_for("first pulse", 0, 1'b1, 1000, n);
      repeat (2100) @(negedge clk_in);
      chk("limit ramped", LIM_DEFAULT, drv.limit_code);
      lim_set = 8'h80;
      repeat (5) @(negedge clk_in);
      chk("user limit", 8'h80, drv.limit_code);
      lim_set = 8'h00;
      $display("startup done");
   endtask
   task automatic t_period();
      wait_for("fall", 0, 1'b0, 1000, n);
      wait_for("rise", 0, 1'b1, 1000, n);
      wait_for("on end", 0, 1'b0, 1000, n);
      wait_for("rise", 0, 1'b1, 1000, m);
      chk("dmax on", 8'h01, 8'(n >= 600 && n <= 710));
      chk("period", 8'h01, 8'(n + m >= 800 && n + m <= 940));
      chk("aux charger", 8'h00, {7'h00, drv.charger_en});
      sns.above_charger_on = 1'b0;
      wait_for("self bias", 3, 1'b1, 1000, n);
      wait_for("rise", 0, 1'b1, 1000, n);
      @(negedge clk_in);
      chk("charger on-time", 8'h00, {7'h00, drv.charger_en});
      sns.above_charger_on = 1'b1;
      load = 2'h1;
      wait_for("rise", 0, 1'b1, 1000, n);
      wait_for("pwm end", 0, 1'b0, 1000, n);
      chk("pwm on", 8'h01, 8'(n >= 95 && n <= 110));
      // Saturated compensation: the ramp comparator no longer ends pulses
      sns.comp_saturated = 1'b1;
      wait_for("sat rise", 0, 1'b1, 1000, n);
      wait_for("sat end", 0, 1'b0, 1000, n);
      chk("sat clamp", 8'h01, 8'(n >= 600));
      sns.comp_saturated = 1'b0;
      load = 2'h0;
      sns.feedback_grounded = 1'b1;
      sns.feedback_open = 1'b1;
      repeat (4) @(negedge clk_in);
      chk("ea off", 8'h01, {7'h00, drv.ea_disable});
      chk("pull up", 8'h01, {7'h00, drv.fb_pullup_en});
      sns.feedback_grounded = 1'b0;
      sns.feedback_open = 1'b0;
      $display("period done");
   endtask
   task automatic t_burst();
      sns.comp_below_burst = 1'b1;
      wait_for("burst in", 1, 1'b1, 10, n);
      sns.comp_below_burst = 1'b0;
      repeat (2000) @(negedge clk_in);
      chk("burst limit", LIM_BURST, drv.limit_code);
      chk("burst hold", 8'h01, {7'h00, burst});
      sns.comp_above_hys = 1'b1;
      wait_for("burst out", 1, 1'b0, 10, n);
      wait_for("resume", 0, 1'b1, 1000, n);
      $display("burst done");
   endtask
   task automatic t_overload();
      load = 2'h2;
      // Three limit cycles, one short of the trip count
      repeat (3) begin
         wait_for("hit on", 0, 1'b1, 1000, n);
         wait_for("hit", 0, 1'b0, 1000, n);
      end
      load = 2'h0;
      repeat (10) begin
         wait_for("rise", 0, 1'b1, 1000, n);
         wait_for("fall", 0, 1'b0, 1000, n);
         chk("no trip", 8'h00, {7'h00, ovl});
      end
      load = 2'h2;
      sns.comp_saturated = 1'b1;
      wait_for("trip", 2, 1'b1, 5000, n);
      // Counter must have drained to zero: four full hit cycles needed
      chk("trip delay", 8'h01, 8'(n >= 2500));
      repeat (RS_CYC - 10) @(negedge clk_in);
      chk("still wait", 8'h01, {7'h00, ovl});
      wait_for("restart", 2, 1'b0, 30, n);
      // Limit code follows the ramp register one edge later
      @(negedge clk_in);
      chk("new ramp", LIM_SS_START, drv.limit_code);
      wait_for("trip again", 2, 1'b1, 5000, n);
      load = 2'h0;
      sns.comp_saturated = 1'b0;
      wait_for("recover", 2, 1'b0, 600, n);
      wait_for("rise", 0, 1'b1, 1000, n);
      $display("overload done");
   endtask
   task automatic t_undervoltage_lockout();
      sns.above_turn_off = 1'b0;
      sns.above_turn_on = 1'b0;
      repeat (2000) @(negedge clk_in);
      chk("stopped", 8'h00, {7'h00, drv.gate});
      $display("lockout done");
   endtask
   initial begin
      repeat (6) @(negedge clk_in);
      t_startup();
      t_period();
      t_burst();
      t_overload();
      t_undervoltage_lockout();
      wrap_up();
   end
endmodule // offline_pwm_converter_control_tb_top
`default_nettype wire

// *** bench/opc_control_sva.sv ***
// Assertion checker for the converter control top
`timescale 1ns/1ns
`default_nettype none
module opc_control_sva #(
   parameter longint RESTART_CYC_P = 500
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire opc_pkg::opc_sense_t sense_in,
   input wire logic [7:0] limit_set_code_in,
   input wire opc_pkg::opc_drive_t drive_out,
   input wire logic burst_out,
   input wire logic overload_out
);
   import opc_pkg::*;
   // Slowest jittered period bounds the on-time of the high variant
   localparam int ON_MAX = CLK_HZ / (FSW_HIGH_HZ - DEPTH_HIGH_HZ)
      * DMAX_PCT / 100 + 2;
   int on_reg;
   int ovl_reg;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   // Run lengths of gate and restart wait, cleared in reset
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         on_reg <= 0;
         ovl_reg <= 0;
      end else begin
         on_reg <= drive_out.gate ? on_reg + 1 : 0;
         ovl_reg <= overload_out ? ovl_reg + 1 : 0;
      end
   end
   property p_undervoltage_lockout_gate;
      !sense_in.above_turn_off [*2] |=> !drive_out.gate;
   endproperty
   a_undervoltage_lockout_gate: assert property (p_undervoltage_lockout_gate)
      else $error("gate high below turn-off");
   property p_pwm_off;
      drive_out.gate && sense_in.pwm_trip && !sense_in.comp_saturated
         |=> !drive_out.gate;
   endproperty
   a_pwm_off: assert property (p_pwm_off)
      else $error("gate kept after pwm trip");
   property p_lim_off;
      drive_out.gate && sense_in.limit_trip |=> !drive_out.gate;
   endproperty
   a_lim_off: assert property (p_lim_off)
      else $error("gate kept after limit trip");
   property p_dmax;
      on_reg <= ON_MAX;
   endproperty
   a_dmax: assert property (p_dmax)
      else $error("on-time past maximum duty");
   property p_burst_off;
      burst_out && $past(burst_out) |-> !drive_out.gate && drive_out.low_power;
   endproperty
   a_burst_off: assert property (p_burst_off)
      else $error("switching or full power in burst");
   property p_burst_lim;
      burst_out && $past(burst_out) |-> drive_out.limit_code == LIM_BURST;
   endproperty
   a_burst_lim: assert property (p_burst_lim)
      else $error("wrong limit in burst");
   property p_burst_hys;
      burst_out && !sense_in.comp_above_hys && sense_in.above_turn_off
         |=> burst_out;
   endproperty
   a_burst_hys: assert property (p_burst_hys)
      else $error("burst left below hysteresis");
   property p_ovl_gate;
      overload_out |-> !drive_out.gate;
   endproperty
   a_ovl_gate: assert property (p_ovl_gate)
      else $error("gate during restart wait");
   property p_restart_len;
      $fell(overload_out) |-> ovl_reg + 2 >= RESTART_CYC_P
         && ovl_reg <= RESTART_CYC_P + 2;
   endproperty
   a_restart_len: assert property (p_restart_len)
      else $error("restart wait length wrong");
   property p_fb_gnd;
      sense_in.feedback_grounded |-> ##[1:3]
         (drive_out.ea_disable && drive_out.comp_res_en);
   endproperty
   a_fb_gnd: assert property (p_fb_gnd)
      else $error("grounded feedback not handled");
   property p_fb_open;
      sense_in.feedback_open |-> ##[1:3] drive_out.fb_pullup_en;
   endproperty
   a_fb_open: assert property (p_fb_open)
      else $error("open feedback not pulled up");
   property p_chg_gate;
      drive_out.gate |-> !drive_out.charger_en;
   endproperty
   a_chg_gate: assert property (p_chg_gate)
      else $error("charger on while switch conducts");
endmodule // opc_control_sva
bind opc_control opc_control_sva #(.RESTART_CYC_P(RESTART_CYC_P)) chk_u (
   .clk_in(clk_in),
   .rst_n_in(rst_n_in),
   .sense_in(sense_in),
   .limit_set_code_in(limit_set_code_in),
   .drive_out(drive_out),
   .burst_out(burst_out),
   .overload_out(overload_out)
);
`default_nettype wire

// *** bench/opc_sense_model.sv ***
// Far-side model: switch current seen by the two current comparators
`timescale 1ns/1ns
`default_nettype none
module opc_sense_model (
   input wire logic clk_in,
   input wire logic gate_in,
   input wire logic [1:0] load_in,
   output logic pwm_trip_out = 1'b0,
   output logic limit_trip_out = 1'b0
);
   int on_cnt = 0;
   // Current ramps while the switch conducts and drops to zero once it opens
   always @(negedge clk_in) begin
      on_cnt <= gate_in ? on_cnt + 1 : 0;
      pwm_trip_out <= gate_in && load_in == 2'h1 && on_cnt >= 100;
      limit_trip_out <= gate_in && load_in == 2'h2 && on_cnt >= 50;
   end
endmodule // opc_sense_model
`default_nettype wire

// *** core/opc_control.sv ***
// Top of the off-line converter control logic
`timescale 1ns/1ns
`default_nettype none
module opc_control #(
   parameter bit HIGH_FREQ = 1'b0,
   parameter int SOFT_START_CYC_P = opc_pkg::SOFT_START_CYC,
   parameter longint RESTART_CYC_P = opc_pkg::RESTART_CYC,
   parameter int SWEEP_CYC_P = opc_pkg::SWEEP_CYC,
   parameter int OVERLOAD_SW_P = HIGH_FREQ ? opc_pkg::OVERLOAD_HIGH_SW
      : opc_pkg::OVERLOAD_LOW_SW
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire opc_pkg::opc_sense_t sense_in,
   input wire logic [7:0] limit_set_code_in,
   output opc_pkg::opc_drive_t drive_out,
   output logic burst_out,
   output logic overload_out
);
   import opc_pkg::*;

   typedef struct packed {
      opc_state_t st;
      logic first_done;
      logic [7:0] ss_lim;
      logic [31:0] tmr;
      logic [39:0] rst_tmr;
      logic burst;
      logic chg;
      logic on_reg;
      logic hit;
      opc_drive_t drv;
   } opc_ctl_t;

   opc_ctl_t s_reg, s_next;
   logic cyc_start;
   logic dmax;
   logic ovl_trip;
   logic ovl_clear;
   logic [7:0] user_lim;
   logic [7:0] act_lim;
   logic [31:0] ss_step;

   // Smaller of two limit codes
   function automatic logic [7:0] opc_min(input logic [7:0] a,
         input logic [7:0] b);
      opc_min = (a < b) ? a : b;
   endfunction

   opc_oscillator #(
      .HIGH_FREQ(HIGH_FREQ),
      .SWEEP_CYC_P(SWEEP_CYC_P)
   ) u_osc (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .cycle_start_out(cyc_start),
      .dmax_out(dmax)
   );

   opc_overload #(
      .TRIP_SW(OVERLOAD_SW_P)
   ) u_ovl (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .cycle_end_in(cyc_start && s_reg.st == OPC_ST_RUN),
      .hit_in(s_reg.hit),
      .clear_in(ovl_clear),
      .trip_out(ovl_trip)
   );

   // Counter cleared whenever not running so a new start counts from zero
   assign ovl_clear = (s_reg.st != OPC_ST_RUN);

   // Zero code means open pin or high resistor: default limit applies
   assign user_lim = (limit_set_code_in == 8'h00) ? LIM_DEFAULT
      : limit_set_code_in;

   // Active limit: smallest of user setting, soft start ramp and, in burst, the burst limit
   always_comb begin
      act_lim = opc_min(user_lim, s_reg.ss_lim);
      if (s_reg.burst) begin
         act_lim = opc_min(act_lim, LIM_BURST);
      end
   end

   // One ramp step per soft-start slice, ramp spans LIM_SS_START up to LIM_DEFAULT
   assign ss_step = 32'(SOFT_START_CYC_P) / 32'(LIM_DEFAULT - LIM_SS_START);

   // Main sequencer
   always_comb begin
      s_next = s_reg;
      s_next.drv.ea_disable = sense_in.feedback_grounded;
      s_next.drv.comp_res_en = sense_in.feedback_grounded;
      s_next.drv.fb_pullup_en = 1'b1; // Weak pull keeps open pin high
      s_next.drv.limit_code = act_lim; // Active limit, registered
      s_next.drv.charger_en = 1'b0;
      case (s_reg.st)
         OPC_ST_OFF: begin
            // Lockout: wait for bulk voltage
            s_next.on_reg = 1'b0;
            if (sense_in.drain_start) begin
               s_next.st = OPC_ST_CHARGE;
            end
         end
         OPC_ST_CHARGE: begin
            s_next.on_reg = 1'b0;
            s_next.drv.charger_en = 1'b1;
            if (sense_in.above_turn_on) begin
               s_next.drv.charger_en = 1'b0;
               s_next.st = OPC_ST_RUN;
               s_next.first_done = 1'b1;
               s_next.chg = 1'b0;
               s_next.ss_lim = LIM_SS_START;
               s_next.tmr = 32'h0;
               s_next.burst = 1'b0;
            end
         end
         OPC_ST_RUN: begin
            // Soft start ramp by counted clocks
            if (s_reg.ss_lim != LIM_DEFAULT) begin
               if (s_reg.tmr + 32'h1 >= ss_step) begin
                  s_next.tmr = 32'h0;
                  s_next.ss_lim = s_reg.ss_lim + 8'h1;
               end else begin
                  s_next.tmr = s_reg.tmr + 32'h1;
               end
            end
            // Burst entry and exit with hysteresis
            if (!s_reg.burst && sense_in.comp_below_burst) begin
               s_next.burst = 1'b1;
            end else if (s_reg.burst && sense_in.comp_above_hys) begin
               s_next.burst = 1'b0;
            end
            // Charger latch: set below charger-on, cleared at turn-on, so
            // an auxiliary supply that stays above charger-on never sets it
            if (!sense_in.above_charger_on) begin
               s_next.chg = 1'b1;
            end else if (sense_in.above_turn_on) begin
               s_next.chg = 1'b0;
            end
            // Cycle by cycle gating
            if (cyc_start) begin
               s_next.hit = 1'b0;
               s_next.on_reg = !s_next.burst;
            end else if (s_reg.on_reg) begin
               if (sense_in.limit_trip) begin
                  s_next.on_reg = 1'b0;
                  s_next.hit = 1'b1;
               end else if ((sense_in.pwm_trip && !sense_in.comp_saturated)
                  || dmax) begin
                  // Saturated compensation: only the limit or the duty
                  // ceiling ends the pulse, peak sits at the limit
                  s_next.on_reg = 1'b0;
               end
            end
            // Burst stops the pulse at once rather than at the duty ceiling
            if (s_next.burst) begin
               s_next.on_reg = 1'b0;
            end
            if (ovl_trip) begin
               s_next.on_reg = 1'b0;
               s_next.st = OPC_ST_RESTART;
               s_next.rst_tmr = 40'h0;
            end
            if (!sense_in.above_turn_off) begin
               s_next.on_reg = 1'b0;
               s_next.st = OPC_ST_OFF;
            end
            // Charger only in switch off time, never beside a gate pulse
            s_next.drv.charger_en = s_next.chg && !s_next.on_reg
               && s_next.st == OPC_ST_RUN;
         end
         OPC_ST_RESTART: begin
            // Wait then restart through a fresh soft start
            s_next.on_reg = 1'b0;
            s_next.rst_tmr = s_reg.rst_tmr + 40'h1;
            if (s_reg.rst_tmr + 40'h1 >= 40'(RESTART_CYC_P)) begin
               s_next.st = OPC_ST_RUN;
               s_next.ss_lim = LIM_SS_START;
               s_next.tmr = 32'h0;
               s_next.burst = 1'b0;
            end
            if (!sense_in.above_turn_off) begin
               s_next.st = OPC_ST_OFF;
            end
         end
         default: begin
            s_next.st = OPC_ST_OFF;
         end
      endcase
      s_next.drv.gate = s_next.on_reg && s_next.st == OPC_ST_RUN;
      s_next.drv.low_power = s_next.burst || s_next.st != OPC_ST_RUN;
      if (!rst_n_in) begin
         s_next = '0;
         s_next.st = OPC_ST_OFF;
         s_next.ss_lim = LIM_SS_START;
         s_next.drv.fb_pullup_en = 1'b1;
         s_next.drv.limit_code = LIM_SS_START;
      end
   end

   always_ff @(posedge clk_in) begin
      s_reg <= s_next;
   end

   // Outputs straight from state
   assign drive_out = s_reg.drv;
   assign burst_out = s_reg.burst;
   assign overload_out = (s_reg.st == OPC_ST_RESTART);

endmodule : opc_control
`default_nettype wire

// *** core/opc_oscillator.sv ***
// Jittered switching clock: cycle start pulse and maximum duty point
`timescale 1ns/1ns
`default_nettype none
module opc_oscillator #(
   parameter bit HIGH_FREQ = 1'b0,
   parameter int SWEEP_CYC_P = opc_pkg::SWEEP_CYC
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   output logic cycle_start_out,
   output logic dmax_out
);
   import opc_pkg::*;
   localparam int BASE = HIGH_FREQ ? PERIOD_HIGH_CYC : PERIOD_LOW_CYC;
   localparam int SWING = HIGH_FREQ ? SWING_HIGH_CYC : SWING_LOW_CYC;
   localparam int HALF = SWEEP_CYC_P / 2;
   typedef struct packed {
      logic [15:0] ph;
      logic [15:0] len;
      logic [23:0] sw;
      logic start;
      logic dmax;
   } opc_osc_t;
   opc_osc_t s_reg, s_next;
   logic [39:0] prod;
   // Triangle sweep sets period length around nominal
   always_comb begin
      s_next = s_reg;
      prod = 40'(s_reg.sw < 24'(HALF) ? s_reg.sw : 24'(SWEEP_CYC_P) - s_reg.sw)
         * 40'(2 * SWING);
      s_next.sw = (s_reg.sw >= 24'(SWEEP_CYC_P - 1)) ? 24'h0 : s_reg.sw + 24'h1;
      s_next.start = 1'b0;
      if (s_reg.ph + 16'h1 >= s_reg.len) begin
         s_next.ph = 16'h0;
         s_next.start = 1'b1;
         // Triangle peak adds twice the swing: period runs both sides
         s_next.len = 16'(BASE - SWING) + 16'(prod / 40'(HALF));
      end else begin
         s_next.ph = s_reg.ph + 16'h1;
      end
      // Duty ceiling at fixed fraction of current period
      s_next.dmax = 32'(s_reg.ph) * 32'd100 >= 32'(s_reg.len) * 32'(DMAX_PCT);
      if (!rst_n_in) begin
         s_next = '0;
         s_next.len = 16'(BASE);
      end
   end
   always_ff @(posedge clk_in) begin
      s_reg <= s_next;
   end
   assign cycle_start_out = s_reg.start;
   assign dmax_out = s_reg.dmax;
endmodule : opc_oscillator
`default_nettype wire

// *** core/opc_overload.sv ***
// Up-down overload counter, one step per switching cycle
`timescale 1ns/1ns
`default_nettype none
module opc_overload #(
   parameter int TRIP_SW = opc_pkg::OVERLOAD_LOW_SW
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic cycle_end_in,
   input wire logic hit_in,
   input wire logic clear_in,
   output logic trip_out
);
   import opc_pkg::*;
   typedef struct packed {
      logic [15:0] cnt;
      logic trip;
   } opc_ovl_t;
   opc_ovl_t s_reg, s_next;
   // Count up on limit cycles, down otherwise, saturating at zero
   always_comb begin
      s_next = s_reg;
      s_next.trip = 1'b0;
      if (cycle_end_in) begin
         if (hit_in) begin
            s_next.cnt = s_reg.cnt + 16'h1;
         end else if (s_reg.cnt != 16'h0) begin
            s_next.cnt = s_reg.cnt - 16'h1;
         end
         if (hit_in && s_reg.cnt + 16'h1 >= 16'(TRIP_SW)) begin
            s_next.trip = 1'b1;
            s_next.cnt = 16'h0;
         end
      end
      if (!rst_n_in || clear_in) begin
         s_next = '0;
      end
   end
   always_ff @(posedge clk_in) begin
      s_reg <= s_next;
   end
   assign trip_out = s_reg.trip;
endmodule : opc_overload
`default_nettype wire

// *** core/opc_pkg.sv ***
// Package with constants and carrier types of the converter control block
`default_nettype none
package opc_pkg;
   // Clock and timing figures
   localparam int CLK_HZ = 100_000_000;
   localparam int FSW_LOW_HZ = 60_000;
   localparam int FSW_HIGH_HZ = 115_000;
   localparam int DEPTH_LOW_HZ = 4_000;
   localparam int DEPTH_HIGH_HZ = 8_000;
   localparam int SWEEP_HZ = 230;
   localparam int SOFT_START_TIME_US = 8_500;
   localparam int OVERLOAD_TRIP_TIME_US = 50_000;
   localparam int RESTART_WAIT_TIME_MS = 1_000;
   localparam int DMAX_PCT = 75;
   // Derived cycle counts
   localparam int PERIOD_LOW_CYC = CLK_HZ / FSW_LOW_HZ;
   localparam int PERIOD_HIGH_CYC = CLK_HZ / FSW_HIGH_HZ;
   localparam int SWING_LOW_CYC = CLK_HZ / (FSW_LOW_HZ - DEPTH_LOW_HZ)
      - PERIOD_LOW_CYC;
   localparam int SWING_HIGH_CYC = CLK_HZ / (FSW_HIGH_HZ - DEPTH_HIGH_HZ)
      - PERIOD_HIGH_CYC;
   localparam int SWEEP_CYC = CLK_HZ / SWEEP_HZ;
   localparam int SOFT_START_CYC = (CLK_HZ / 1_000_000) * SOFT_START_TIME_US;
   localparam int OVERLOAD_LOW_SW = OVERLOAD_TRIP_TIME_US * FSW_LOW_HZ
      / 1_000_000;
   localparam int OVERLOAD_HIGH_SW = OVERLOAD_TRIP_TIME_US / 1_000
      * FSW_HIGH_HZ / 1_000;
   localparam longint RESTART_CYC = longint'(CLK_HZ) / 1_000
      * RESTART_WAIT_TIME_MS;
   // Limit code widths and values
   localparam int LIM_W = 8;
   localparam logic [7:0] LIM_DEFAULT = 8'hff;
   localparam logic [7:0] LIM_BURST = 8'h36;   // 85 mA of 400 mA full code
   localparam logic [7:0] LIM_SS_START = 8'h20;
   // Controller states
   typedef enum logic [2:0] {
      OPC_ST_OFF = 3'b000,
      OPC_ST_CHARGE = 3'b001,
      OPC_ST_RUN = 3'b010,
      OPC_ST_RESTART = 3'b011
   } opc_state_t;
   // Comparator and supply sense inputs
   typedef struct packed {
      logic drain_start;       // Bulk voltage above drain start threshold
      logic above_turn_on;     // Supply above turn-on threshold
      logic above_charger_on;  // Supply above charger-on threshold
      logic above_turn_off;    // Supply above turn-off threshold
      logic pwm_trip;          // Sense current reached compensation level
      logic limit_trip;        // Sense current above active limit
      logic comp_below_burst;  // Compensation below burst threshold
      logic comp_above_hys;    // Compensation above threshold plus hysteresis
      logic comp_saturated;    // Compensation above upper saturation level
      logic feedback_grounded; // Feedback pin tied low
      logic feedback_open;     // Feedback pin floating
   } opc_sense_t;
   // Control outputs to the analogue side
   typedef struct packed {
      logic gate;
      logic charger_en;
      logic ea_disable;
      logic comp_res_en;
      logic fb_pullup_en;
      logic low_power;
      logic [7:0] limit_code;
   } opc_drive_t;
endpackage : opc_pkg
`default_nettype wire
